/* hw/pmic_cfg_pkg.sv */
// pmic_cfg_pkg: register indices, reset values, field positions and carriers
// for the channel configuration register slice.
// assumes an AHB-Lite word bus where byte address = 4 * register index.
`default_nettype none

package pmic_cfg_pkg;

    // register indices; byte address is index * 4
    localparam logic [5:0] IDX_DELAY = 6'h1e;
    localparam logic [5:0] IDX_UNUSED = 6'h1f;
    localparam logic [5:0] IDX_SLOPE = 6'h20;
    localparam logic [5:0] IDX_ZFREQ = 6'h21;
    localparam logic [5:0] IDX_CTL = 6'h22;
    localparam logic [5:0] IDX_SOFT_RESET_TRIGGER = 6'h23;
    localparam logic [5:0] IDX_FLAGS = 6'h30;
    localparam logic [5:0] IDX_CH1OPT = 6'h31;
    localparam logic [5:0] IDX_CH12_COMPENSATION = 6'h32;

    // reset values
    localparam logic [7:0] RST_DELAY = 8'h05;
    localparam logic [7:0] RST_UNUSED = 8'h00;
    localparam logic [7:0] RST_SLOPE = 8'h04;
    localparam logic [7:0] RST_ZFREQ = 8'h40;
    localparam logic [7:0] RST_CTL = 8'h07;
    localparam logic [7:0] RST_SOFT_RESET_TRIGGER = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CH1OPT = 8'h02;
    localparam logic [7:0] RST_CH12_COMPENSATION = 8'h00;

    // implemented bits; the rest read as zero
    localparam logic [7:0] MASK_DELAY = 8'h3f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_ZFREQ = 8'h70;
    localparam logic [7:0] MASK_CTL = 8'h7f;
    localparam logic [7:0] MASK_CH1OPT = 8'h0f;
    localparam logic [7:0] MASK_CH12_COMPENSATION = 8'hf0;

    localparam logic [7:0] SOFT_RESET_TRIGGER_TRIGGER = 8'h55;

    // field positions
    localparam int CTL_FORCE_BIT = 6;
    localparam int CTL_PG_TYPE_BIT = 3;
    localparam int CTL_AUX_LSB = 4;
    localparam int CH1_TH_LSB = 2;
    localparam int CH1_PSKIP_BIT = 1;
    localparam int CH1_STEPDOWN_BIT = 0;
    localparam int ZF_BAND_LSB = 5;
    localparam int ZF_EXT_BIT = 4;
    localparam int CMP_LF_LSB = 6;
    localparam int CMP_HF_LSB = 4;
    localparam int CTL_PSKIP_LSB = 0;
    localparam int DELAY_LSB = 0;
    localparam int SLP_CH4_LSB = 6;
    localparam int SLP_CH3_LSB = 4;
    localparam int SLP_CH2_LSB = 2;
    localparam int SLP_CH1_LSB = 0;

    // delay step of the channel-3 limit timer code
    localparam int DELAY_STEP_US = 1050;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic {PH_IDLE = 1'b0, PH_WRITE = 1'b1} phase_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ahb_rsp_t;

    typedef struct packed {
        logic [5:0] ch3_delay_code;
        logic [1:0] ch4_slope_select;
        logic [1:0] ch3_ramp_select;
        logic [1:0] ch2_slope_select;
        logic [1:0] ch1_slope_select;
        logic [1:0] ch3_filter_band;
        logic ch3_ext_transistor_limit;
        logic [1:0] aux_regulator_voltage;
        logic [2:0] pulse_skip_ch432;
        logic ch1_pulse_skip;
        logic [1:0] ch1_transition_threshold;
        logic step_down_only;
        logic [1:0] ch2_lf_pole_select;
        logic [1:0] ch2_hf_gain_select;
    } cfg_fields_t;

endpackage : pmic_cfg_pkg

`default_nettype wire

/* hw/pmic_channel_config_regs.sv */
// pmic_channel_config_regs: channel configuration and status registers
// behind an AHB-Lite slave, zero wait states.
// assumes single-word transfers and synchronous inputs on mclk.
//
// How it works
// - the channel-3 delay code is six bits, 1.05 ms a step, reset code 5.
// - writing 0x55 to the soft reset register starts a soft reset.
// - a soft reset restores every default except flags set by a same-cycle hard short event, and shuts the device down.
// - control bit 6 lets switch one bypass global enable and disables its current limit.
// - forced switch one follows only its enable bit, even with enable low.
// - the aux regulator field is two bits with default code 00.
// - control bit 3 picks open drain (0) or push-pull (1) for power good.
// - control bits 2..0 enable pulse skipping on channels 4..2, default 1.
// - the hard-short flag register is read-only sticky, reset to 0.
// - the channel-1 threshold field is two bits, default 00.
// - channel-1 options bit 1 pulse skip (default 1), bit 0 step-down only.
// - channel-3 filter band is bits 6:5 with default code 10.
// - channel-3 external transistor limit bit 4 defaults to 0.
// - channel-2 low-frequency pole field is bits 7:6, default 00.
// - channel-2 high-frequency gain field is bits 5:4, default 00.
`timescale 1ns/100ps
`default_nettype none

module pmic_channel_config_regs
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire pmic_cfg_pkg::ahb_req_t ahb_req,
    output pmic_cfg_pkg::ahb_rsp_t ahb_rsp,
    input wire logic [7:0] hard_short_event,
    input wire logic global_enable,
    input wire logic channel_one_enable_reg,
    input wire logic power_good_level,
    output pmic_cfg_pkg::cfg_fields_t cfg,
    output logic soft_reset_pulse,
    output logic load_switch_one,
    output logic switch_one_limit_enable,
    output logic power_good_out,
    output logic power_good_oe
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] delay;
        logic [7:0] unused;
        logic [7:0] slope;
        logic [7:0] zfreq;
        logic [7:0] ctl;
        logic [7:0] soft_reset_trigger;
        logic [7:0] flags;
        logic [7:0] ch1opt;
        logic [7:0] ch12_compensation;
        pmic_cfg_pkg::phase_t phase;
        logic [5:0] index;
        logic [31:0] rdata;
        logic sreset;
    } state_t;

    state_t cur;
    state_t next_cur;

    function automatic logic [7:0] read_reg(input state_t s,
                                            input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            pmic_cfg_pkg::IDX_DELAY: v = s.delay;
            pmic_cfg_pkg::IDX_UNUSED: v = s.unused;
            pmic_cfg_pkg::IDX_SLOPE: v = s.slope;
            pmic_cfg_pkg::IDX_ZFREQ: v = s.zfreq;
            pmic_cfg_pkg::IDX_CTL: v = s.ctl;
            pmic_cfg_pkg::IDX_SOFT_RESET_TRIGGER: v = s.soft_reset_trigger;
            pmic_cfg_pkg::IDX_FLAGS: v = s.flags;
            pmic_cfg_pkg::IDX_CH1OPT: v = s.ch1opt;
            pmic_cfg_pkg::IDX_CH12_COMPENSATION: v = s.ch12_compensation;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    logic addr_ok;
    logic take;
    logic [7:0] wbyte;

    assign addr_ok = (ahb_req.haddr[31:8] == 24'h000000)
        && (ahb_req.haddr[1:0] == 2'b00);
    assign take = ahb_req.hsel && ahb_req.hready
        && (ahb_req.htrans == pmic_cfg_pkg::HTRANS_NONSEQ);
    assign wbyte = ahb_req.hwdata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_cur = cur;
        next_cur.sreset = 1'b0;
        // data phase of a write
        if (cur.phase == pmic_cfg_pkg::PH_WRITE)
        begin
            case (cur.index)
                pmic_cfg_pkg::IDX_DELAY:
                    next_cur.delay = wbyte & pmic_cfg_pkg::MASK_DELAY;
                pmic_cfg_pkg::IDX_UNUSED:
                    next_cur.unused = wbyte;
                pmic_cfg_pkg::IDX_SLOPE:
                    next_cur.slope = wbyte;
                pmic_cfg_pkg::IDX_ZFREQ:
                    next_cur.zfreq = wbyte & pmic_cfg_pkg::MASK_ZFREQ;
                pmic_cfg_pkg::IDX_CTL:
                    next_cur.ctl = wbyte & pmic_cfg_pkg::MASK_CTL;
                pmic_cfg_pkg::IDX_SOFT_RESET_TRIGGER:
                    next_cur.soft_reset_trigger = wbyte;
                pmic_cfg_pkg::IDX_CH1OPT:
                    next_cur.ch1opt = wbyte & pmic_cfg_pkg::MASK_CH1OPT;
                pmic_cfg_pkg::IDX_CH12_COMPENSATION:
                    next_cur.ch12_compensation = wbyte & pmic_cfg_pkg::MASK_CH12_COMPENSATION;
                default:
                    next_cur.index = cur.index; // flags are read-only
            endcase
            if (cur.index == pmic_cfg_pkg::IDX_SOFT_RESET_TRIGGER
                && wbyte == pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER)
            begin
                // every register back to default
                next_cur.delay = pmic_cfg_pkg::RST_DELAY;
                next_cur.unused = pmic_cfg_pkg::RST_UNUSED;
                next_cur.slope = pmic_cfg_pkg::RST_SLOPE;
                next_cur.zfreq = pmic_cfg_pkg::RST_ZFREQ;
                next_cur.ctl = pmic_cfg_pkg::RST_CTL;
                next_cur.soft_reset_trigger = pmic_cfg_pkg::RST_SOFT_RESET_TRIGGER;
                next_cur.flags = pmic_cfg_pkg::RST_FLAGS;
                next_cur.ch1opt = pmic_cfg_pkg::RST_CH1OPT;
                next_cur.ch12_compensation = pmic_cfg_pkg::RST_CH12_COMPENSATION;
                next_cur.sreset = 1'b1;
            end
        end
        // sticky flags: a new event wins over the soft reset clear
        next_cur.flags = next_cur.flags | hard_short_event;
        // address phase
        next_cur.phase = pmic_cfg_pkg::PH_IDLE;
        if (take)
        begin
            next_cur.index = addr_ok ? ahb_req.haddr[7:2] : 6'h00;
            if (ahb_req.hwrite)
            begin
                next_cur.phase = pmic_cfg_pkg::PH_WRITE;
            end
            else
            begin
                next_cur.rdata = {24'h000000,
                    addr_ok ? read_reg(cur, ahb_req.haddr[7:2]) : 8'h00};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '{delay: pmic_cfg_pkg::RST_DELAY,
                     unused: pmic_cfg_pkg::RST_UNUSED,
                     slope: pmic_cfg_pkg::RST_SLOPE,
                     zfreq: pmic_cfg_pkg::RST_ZFREQ,
                     ctl: pmic_cfg_pkg::RST_CTL,
                     soft_reset_trigger: pmic_cfg_pkg::RST_SOFT_RESET_TRIGGER,
                     flags: pmic_cfg_pkg::RST_FLAGS,
                     ch1opt: pmic_cfg_pkg::RST_CH1OPT,
                     ch12_compensation: pmic_cfg_pkg::RST_CH12_COMPENSATION,
                     phase: pmic_cfg_pkg::PH_IDLE,
                     index: 6'h00,
                     rdata: 32'h00000000,
                     sreset: 1'b0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp = pmic_cfg_pkg::HRESP_OKAY;
    assign ahb_rsp.hrdata = cur.rdata;

    assign cfg.ch3_delay_code =
        cur.delay[pmic_cfg_pkg::DELAY_LSB +: 6];
    assign cfg.ch4_slope_select =
        cur.slope[pmic_cfg_pkg::SLP_CH4_LSB +: 2];
    assign cfg.ch3_ramp_select =
        cur.slope[pmic_cfg_pkg::SLP_CH3_LSB +: 2];
    assign cfg.ch2_slope_select =
        cur.slope[pmic_cfg_pkg::SLP_CH2_LSB +: 2];
    assign cfg.ch1_slope_select =
        cur.slope[pmic_cfg_pkg::SLP_CH1_LSB +: 2];
    assign cfg.ch3_filter_band =
        cur.zfreq[pmic_cfg_pkg::ZF_BAND_LSB +: 2];
    assign cfg.ch3_ext_transistor_limit =
        cur.zfreq[pmic_cfg_pkg::ZF_EXT_BIT];
    assign cfg.aux_regulator_voltage =
        cur.ctl[pmic_cfg_pkg::CTL_AUX_LSB +: 2];
    assign cfg.pulse_skip_ch432 =
        cur.ctl[pmic_cfg_pkg::CTL_PSKIP_LSB +: 3];
    assign cfg.ch1_pulse_skip = cur.ch1opt[pmic_cfg_pkg::CH1_PSKIP_BIT];
    assign cfg.ch1_transition_threshold =
        cur.ch1opt[pmic_cfg_pkg::CH1_TH_LSB +: 2];
    assign cfg.step_down_only =
        cur.ch1opt[pmic_cfg_pkg::CH1_STEPDOWN_BIT];
    assign cfg.ch2_lf_pole_select =
        cur.ch12_compensation[pmic_cfg_pkg::CMP_LF_LSB +: 2];
    assign cfg.ch2_hf_gain_select =
        cur.ch12_compensation[pmic_cfg_pkg::CMP_HF_LSB +: 2];

    // soft reset shuts down regardless of global enable
    assign soft_reset_pulse = cur.sreset;

    logic force_on;
    assign force_on = cur.ctl[pmic_cfg_pkg::CTL_FORCE_BIT];
    assign switch_one_limit_enable = !force_on;
    assign load_switch_one = force_on ? channel_one_enable_reg
        : (channel_one_enable_reg && global_enable);

    // open drain only pulls low; push-pull always drives
    logic pg_cmos;
    assign pg_cmos = cur.ctl[pmic_cfg_pkg::CTL_PG_TYPE_BIT];
    assign power_good_out = pg_cmos ? power_good_level : 1'b0;
    assign power_good_oe = pg_cmos ? 1'b1 : !power_good_level;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic data_wr;
    logic soft_reset_trigger_wr;
    assign data_wr = cur.phase == pmic_cfg_pkg::PH_WRITE;
    assign soft_reset_trigger_wr = data_wr && (cur.index == pmic_cfg_pkg::IDX_SOFT_RESET_TRIGGER);

    // one clock domain: all checks share the edge and sleep in reset
    default clocking checks_clk @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_trigger_resets: assert property (
        soft_reset_trigger_wr && wbyte == pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER
        |=> soft_reset_pulse && cur.soft_reset_trigger == pmic_cfg_pkg::RST_SOFT_RESET_TRIGGER)
        else $error("trigger value did not start soft reset");

    a_no_stray_reset: assert property (
        soft_reset_pulse
        |-> $past(soft_reset_trigger_wr && wbyte == pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER))
        else $error("soft reset started without the trigger value");

    a_defaults_restored: assert property (
        $rose(soft_reset_pulse) |-> cur.ctl == pmic_cfg_pkg::RST_CTL
        && cur.delay == pmic_cfg_pkg::RST_DELAY
        && cur.slope == pmic_cfg_pkg::RST_SLOPE
        && cur.zfreq == pmic_cfg_pkg::RST_ZFREQ
        && cur.ch1opt == pmic_cfg_pkg::RST_CH1OPT
        && cur.ch12_compensation == pmic_cfg_pkg::RST_CH12_COMPENSATION)
        else $error("soft reset left a register off default");

    a_flag_set_wins: assert property (
        $rose(soft_reset_pulse)
        |-> cur.flags == (pmic_cfg_pkg::RST_FLAGS | $past(hard_short_event)))
        else $error("soft reset clear lost a new hard short event");

    a_other_value_stored: assert property (
        soft_reset_trigger_wr && wbyte != pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER
        |=> !soft_reset_pulse && cur.soft_reset_trigger == $past(wbyte))
        else $error("non-trigger soft reset write misbehaved");

    a_delay_stored: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_DELAY
        |=> {2'b00, cfg.ch3_delay_code}
        == ($past(wbyte) & pmic_cfg_pkg::MASK_DELAY))
        else $error("delay code not taken from the write");

    a_force_limit: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CTL
        |=> switch_one_limit_enable
        == !$past(wbyte[pmic_cfg_pkg::CTL_FORCE_BIT]))
        else $error("limit enable does not follow force bit");

    a_forced_switch: assert property (
        force_on && !global_enable
        |-> load_switch_one == channel_one_enable_reg)
        else $error("forced switch gated by global enable");

    a_gated_switch: assert property (
        !force_on
        |-> load_switch_one == (channel_one_enable_reg && global_enable))
        else $error("unforced switch ignores global enable");

    a_aux_voltage: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CTL
        |=> cfg.aux_regulator_voltage
        == $past(wbyte[pmic_cfg_pkg::CTL_AUX_LSB +: 2]))
        else $error("aux regulator code not taken from the write");

    a_pg_driver: assert property (
        !pg_cmos |-> !power_good_out && power_good_oe == !power_good_level)
        else $error("open drain power good drives high");

    a_pg_push_pull: assert property (
        pg_cmos |-> power_good_oe && power_good_out == power_good_level)
        else $error("push-pull power good not driven");

    a_pulse_skip: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CTL
        |=> cfg.pulse_skip_ch432
        == $past(wbyte[pmic_cfg_pkg::CTL_PSKIP_LSB +: 3]))
        else $error("pulse skip enables not taken from the write");

    a_flags_sticky: assert property (
        hard_short_event != 8'h00
        |=> (cur.flags & $past(hard_short_event)) == $past(hard_short_event))
        else $error("hard short event not latched");

    a_flags_readonly: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_FLAGS
        |=> cur.flags == ($past(cur.flags) | $past(hard_short_event)))
        else $error("flag register changed by write");

    a_threshold_stored: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CH1OPT
        |=> cfg.ch1_transition_threshold
        == $past(wbyte[pmic_cfg_pkg::CH1_TH_LSB +: 2]))
        else $error("channel-1 threshold not taken from the write");

    a_ch1_options: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CH1OPT
        |=> {cfg.ch1_pulse_skip, cfg.step_down_only}
        == $past(wbyte[pmic_cfg_pkg::CH1_STEPDOWN_BIT +: 2]))
        else $error("channel-1 option bits not taken from the write");

    a_filter_band: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_ZFREQ
        |=> cfg.ch3_filter_band
        == $past(wbyte[pmic_cfg_pkg::ZF_BAND_LSB +: 2]))
        else $error("filter band not taken from the write");

    a_ext_limit: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_ZFREQ
        |=> cfg.ch3_ext_transistor_limit
        == $past(wbyte[pmic_cfg_pkg::ZF_EXT_BIT]))
        else $error("external limit bit not taken from the write");

    a_lf_pole: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CH12_COMPENSATION
        |=> cfg.ch2_lf_pole_select
        == $past(wbyte[pmic_cfg_pkg::CMP_LF_LSB +: 2]))
        else $error("low-frequency pole not taken from the write");

    a_hf_gain: assert property (
        data_wr && cur.index == pmic_cfg_pkg::IDX_CH12_COMPENSATION
        |=> cfg.ch2_hf_gain_select
        == $past(wbyte[pmic_cfg_pkg::CMP_HF_LSB +: 2]))
        else $error("high-frequency gain not taken from the write");

    a_read_upper_zero: assert property (
        ahb_rsp.hrdata[31:8] == 24'h000000 && ahb_rsp.hreadyout)
        else $error("read data upper bits not zero");

    c_soft_reset: cover property (
        soft_reset_pulse);
    c_stored_value: cover property (
        soft_reset_trigger_wr && wbyte != pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER);
    c_forced_low_enable: cover property (
        force_on && !global_enable && load_switch_one);
    c_flag_set: cover property (
        cur.flags != 8'h00);
    c_cmos_pg: cover property (
        pg_cmos && power_good_out);

endmodule : pmic_channel_config_regs

`default_nettype wire

/* tb/pmic_channel_config_regs_test.sv */
// pmic_channel_config_regs_test: self-checking bench for the config slice.
// assumes a zero-wait AHB-Lite slave, byte address = 4 * register index.
`timescale 1ns/100ps
`default_nettype none

module pmic_channel_config_regs_test;

logic mclk;
logic rst_b;
logic hsel;
logic [31:0] haddr;
logic [1:0] htrans;
logic hwrite;
logic [31:0] hwdata;
logic [7:0] hard_short_event;
logic global_enable;
logic channel_one_enable_reg;
logic power_good_level;
pmic_cfg_pkg::ahb_req_t ahb_req;
pmic_cfg_pkg::ahb_rsp_t ahb_rsp;
pmic_cfg_pkg::cfg_fields_t cfg;
logic soft_reset_pulse;
logic load_switch_one;
logic switch_one_limit_enable;
logic power_good_out;
logic power_good_oe;
int fail_count;
int n_tests;
int pulse_count;
logic read_phase = 1'b0;
logic [31:0] exp_q[$];
string name_q[$];
logic [5:0] ridx [9] = '{6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h30,
    6'h31, 6'h32};
logic [7:0] rdef [9] = '{8'h05, 8'h00, 8'h04, 8'h40, 8'h07, 8'h00, 8'h00,
    8'h02, 8'h00};
logic [7:0] rmask [9] = '{8'h3f, 8'hff, 8'hff, 8'h70, 8'h7f, 8'hff, 8'h00,
    8'h0f, 8'hf0};
logic [7:0] wv [9];
logic [7:0] flags;

assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
    hsize: 3'b010, hready: ahb_rsp.hreadyout, hwdata: hwdata};

pmic_channel_config_regs u_pmic_channel_config_regs
(
    .mclk(mclk),
    .rst_b(rst_b),
    .ahb_req(ahb_req),
    .ahb_rsp(ahb_rsp),
    .hard_short_event(hard_short_event),
    .global_enable(global_enable),
    .channel_one_enable_reg(channel_one_enable_reg),
    .power_good_level(power_good_level),
    .cfg(cfg),
    .soft_reset_pulse(soft_reset_pulse),
    .load_switch_one(load_switch_one),
    .switch_one_limit_enable(switch_one_limit_enable),
    .power_good_out(power_good_out),
    .power_good_oe(power_good_oe)
);

initial
begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
end

////////////////////////////////////////////////////////////////////////////
task automatic print_verdict;
    $display("TB: %0d checks, %0d errors", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask : print_verdict

task automatic check_word(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
        fail_count++;
        $display("Error %s: expected %h, seen %h", nm, ex, got);
    end
endtask : check_word

task automatic check_bit(input string nm, input logic ex, input logic got);
    n_tests++;
    if (got !== ex)
    begin
        fail_count++;
        $display("Error %s: expected %b, seen %b", nm, ex, got);
    end
endtask : check_bit

// waits for hready at a rising edge, bounded
task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
        @(posedge mclk);
        n++;
    end
    while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
    if (ahb_rsp.hreadyout !== 1'b1)
    begin
        fail_count++;
        $display("Error hready: expected 1, seen %b", ahb_rsp.hreadyout);
        print_verdict();
    end
endtask : wait_ready

// one single transfer; called just after a rising edge
task automatic bus(input logic wr, input logic [5:0] idx,
    input logic [7:0] wd, input logic [7:0] ex, input string nm);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= pmic_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    if (!wr)
    begin
        exp_q.push_back({24'h0, ex});
        name_q.push_back(nm);
    end
    wait_ready();
endtask : bus

////////////////////////////////////////////////////////////////////////////
// read data monitor: takes the oldest note when a read data phase ends
always @(posedge mclk)
begin
    if (read_phase && ahb_rsp.hreadyout === 1'b1)
    begin
        check_bit("hresp", pmic_cfg_pkg::HRESP_OKAY, ahb_rsp.hresp);
        if (exp_q.size() == 0)
            check_word("unexpected read", 32'h0, 32'hffffffff);
        else
            check_word(name_q.pop_front(), exp_q.pop_front(), ahb_rsp.hrdata);
    end
    read_phase <= hsel && htrans == pmic_cfg_pkg::HTRANS_NONSEQ && !hwrite
        && ahb_rsp.hreadyout;
    if (soft_reset_pulse === 1'b1)
        pulse_count++;
end

////////////////////////////////////////////////////////////////////////////
initial
begin
    {hsel, hwrite} = 2'b00;
    {haddr, hwdata, htrans} = '0;
    hard_short_event = 8'h00;
    {global_enable, channel_one_enable_reg, power_good_level} = 3'b100;
    rst_b = 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    void'($urandom(32'hde40));
    @(posedge mclk);
    for (int i = 0; i < 9; i++)
        bus(1'b0, ridx[i], 8'h00, rdef[i], "reset value");
    for (int i = 0; i < 9; i++)
    begin
        if (i == 5)
            continue;
        wv[i] = 8'($urandom);
        bus(1'b1, ridx[i], wv[i], 8'h00, "");
        bus(1'b0, ridx[i], 8'h00, wv[i] & rmask[i], "readback");
    end
    @(negedge mclk);
    check_word("cfg fields", {2'b0, wv[0][5:0], wv[2], wv[3][6:4],
        wv[4][5:4], wv[4][2:0], wv[7][1], wv[7][3:2], wv[7][0],
        wv[8][7:4]}, {2'b0, cfg});
    @(posedge mclk);
    bus(1'b1, 6'h24, 8'hff, 8'h00, "");
    bus(1'b0, 6'h24, 8'h00, 8'h00, "unmapped");
    flags = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
        hard_short_event <= 8'h01 << i;
        @(posedge mclk);
        hard_short_event <= 8'h00;
        flags[i] = 1'b1;
        bus(1'b0, 6'h30, 8'h00, flags, "hard short flags");
    end
    for (int k = 0; k < 32; k++)
    begin
        bus(1'b1, 6'h22, {1'b0, k[4], 2'b00, k[3], 3'b111}, 8'h00, "");
        channel_one_enable_reg <= k[2];
        global_enable <= k[1];
        power_good_level <= k[0];
        @(negedge mclk);
        check_bit("load switch", k[4] ? k[2] : k[2] & k[1],
            load_switch_one);
        check_bit("limit enable", !k[4], switch_one_limit_enable);
        check_bit("pg oe", k[3] | !k[0], power_good_oe);
        check_bit("pg out", k[3] & k[0], power_good_out);
        @(posedge mclk);
    end
    bus(1'b1, 6'h23, 8'haa, 8'h00, "");
    bus(1'b0, 6'h23, 8'h00, 8'haa, "soft reset store");
    bus(1'b0, 6'h31, 8'h00, wv[7] & 8'h0f, "no reset");
    check_word("pulse count", 32'd0, 32'(pulse_count));
    global_enable <= 1'b0;
    bus(1'b1, 6'h23, pmic_cfg_pkg::SOFT_RESET_TRIGGER_TRIGGER, 8'h00, "");
    for (int i = 0; i < 9; i++)
        bus(1'b0, ridx[i], 8'h00, rdef[i], "after soft reset");
    check_word("pulse count", 32'd1, 32'(pulse_count));
    @(negedge mclk);
    check_word("cfg defaults", {2'b0, rdef[0][5:0], rdef[2],
        rdef[3][6:4], rdef[4][5:4], rdef[4][2:0], rdef[7][1], rdef[7][3:2],
        rdef[7][0], rdef[8][7:4]}, {2'b0, cfg});
    @(posedge mclk);
    check_word("pending reads", 32'd0, 32'(exp_q.size()));
    print_verdict();
end

endmodule : pmic_channel_config_regs_test

`default_nettype wire
